// *** logic/gp5_pin_mux.sv ***
// per-pin choice between plain I/O and alternate function pad control
`timescale 1ns/1ns
module gp5_pin_mux #(
  parameter int NPINS = 13
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic [NPINS*gp5_pkg::GP5_FN_W-1:0]  fn_sel_i,
  input  wire logic [NPINS-1:0]                    io_oe_i,
  input  wire logic [NPINS-1:0]                    io_out_i,
  input  wire gp5_pkg::gp5_pad_t [NPINS-1:0]       alt_pad_i,
  output logic      [NPINS-1:0]                    pad_out_o,
  output logic      [NPINS-1:0]                    pad_oe_o
);

  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      gp5_pkg::gp5_fn_t fn;
      assign fn = gp5_pkg::gp5_fn_t'(fn_sel_i[g*gp5_pkg::GP5_FN_W +: gp5_pkg::GP5_FN_W]);

      // registered pad drive; plain I/O uses the register bits, others the peripheral
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pad_out_o[g] <= 1'b0;
          pad_oe_o[g]  <= 1'b0;
        end
        else if (fn == gp5_pkg::GP5_FN_IO)
        begin
          pad_oe_o[g]  <= io_oe_i[g];
          pad_out_o[g] <= io_out_i[g];
        end
        else
        begin
          // enable bit ignored here, so alternate functions are not disturbed
          pad_oe_o[g]  <= alt_pad_i[g].oe;
          pad_out_o[g] <= alt_pad_i[g].drive;
        end
      end
    end
  endgenerate

endmodule

// *** logic/gp5_pkg.sv ***
// constants, field layout and carrier types for the port 5 pin block
package gp5_pkg;

  localparam int GP5_NPINS = 13;
  localparam int GP5_FN_W  = 2;

  // byte addresses of the register words
  localparam logic [31:0] GP5_ADR_FUNC = 32'hFFF8_3050;
  localparam logic [31:0] GP5_ADR_DIR  = 32'hFFF8_3054;
  localparam logic [31:0] GP5_ADR_DOUT = 32'hFFF8_3058;
  localparam logic [31:0] GP5_ADR_DIN  = 32'hFFF8_305C;

  // field positions inside the direction word
  localparam int GP5_OE_LSB = 0;
  localparam int GP5_PU_LSB = 16;

  // reset values
  localparam logic [31:0] GP5_DIR_RST  = 32'h0000_0000;
  localparam logic [31:0] GP5_FUNC_RST = 32'h0000_0000;
  localparam logic [31:0] GP5_DOUT_RST = 32'h0000_0000;
  localparam logic [31:0] GP5_ZERO     = 32'h0000_0000;

  // two-bit per-pin function codes; only the low code is plain I/O
  typedef enum logic [1:0] {
    GP5_FN_IO   = 2'b00,
    GP5_FN_ALT1 = 2'b01,
    GP5_FN_ALT2 = 2'b10,
    GP5_FN_ALT3 = 2'b11
  } gp5_fn_t;

  // bus answer sequencing
  typedef enum logic [0:0] {
    GP5_BUS_IDLE = 1'b0,
    GP5_BUS_ACK  = 1'b1
  } gp5_bus_t;

  // what a function asks of one pad
  typedef struct packed {
    logic drive;
    logic oe;
  } gp5_pad_t;

  // one bus request, read live from the wishbone inputs
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } gp5_req_t;

endpackage

// *** logic/gp5_port.sv ***
// port 5 pin block: wishbone registers, pad control and live pin levels
`timescale 1ns/1ns
module gp5_port #(
  parameter int NPINS = gp5_pkg::GP5_NPINS
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // classic wishbone slave
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [31:0]                         wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  // pads
  input  wire logic [NPINS-1:0]                    pad_in_i,
  output logic      [NPINS-1:0]                    pad_out_o,
  output logic      [NPINS-1:0]                    pad_oe_o,
  output logic      [NPINS-1:0]                    pullup_en_o,
  // alternate functions sharing the pads
  input  wire gp5_pkg::gp5_pad_t [NPINS-1:0]       alt_pad_i,
  output logic      [NPINS-1:0]                    pin_level_o,
  output logic      [NPINS*gp5_pkg::GP5_FN_W-1:0]  fn_sel_o
);

  localparam int FNW = NPINS * gp5_pkg::GP5_FN_W;

  // stored register state
  logic [NPINS-1:0]     pullup_enable_bits;
  logic [NPINS-1:0]     output_enable_bits;
  logic [NPINS-1:0]     output_value_bits;
  logic [FNW-1:0]       pin_function_selectors;
  logic [NPINS-1:0]     pin_level_bits;

  // bus sequencing
  gp5_pkg::gp5_bus_t    bus_state;
  gp5_pkg::gp5_bus_t    next_bus_state;
  gp5_pkg::gp5_req_t    req;
  logic                 req_valid;
  logic                 wr_fire;
  logic                 hit_func;
  logic                 hit_dir;
  logic                 hit_dout;
  logic                 hit_din;
  logic [31:0]          dir_word;
  logic [31:0]          func_word;
  logic [31:0]          dout_word;
  logic [31:0]          din_word;
  logic [31:0]          next_rdata;
  logic [31:0]          dir_merged;
  logic [31:0]          func_merged;
  logic [31:0]          dout_merged;

  // byte-lane merge: only lanes with sel high take the new byte
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  assign req_valid = wb_cyc_i & wb_stb_i;

  // the request is held stable by the master until ack, so decode it live
  always_comb
  begin
    req.adr = wb_adr_i;
    req.dat = wb_dat_i;
    req.sel = wb_sel_i;
    req.we  = wb_we_i;
  end

  // address decode on the full byte address
  assign hit_func = (req.adr == gp5_pkg::GP5_ADR_FUNC);
  assign hit_dir  = (req.adr == gp5_pkg::GP5_ADR_DIR);
  assign hit_dout = (req.adr == gp5_pkg::GP5_ADR_DOUT);
  assign hit_din  = (req.adr == gp5_pkg::GP5_ADR_DIN);

  // writes commit on the edge that closes the ack cycle
  assign wr_fire = req_valid & req.we & (bus_state == gp5_pkg::GP5_BUS_ACK);

  // register words as software sees them; unused bits read as zero
  always_comb
  begin
    dir_word  = gp5_pkg::GP5_ZERO;
    func_word = gp5_pkg::GP5_ZERO;
    dout_word = gp5_pkg::GP5_ZERO;
    din_word  = gp5_pkg::GP5_ZERO;
    dir_word[gp5_pkg::GP5_PU_LSB +: NPINS] = pullup_enable_bits;
    dir_word[gp5_pkg::GP5_OE_LSB +: NPINS] = output_enable_bits;
    func_word[FNW-1:0]                     = pin_function_selectors;
    dout_word[NPINS-1:0]                   = output_value_bits;
    din_word[NPINS-1:0]                    = pin_level_bits;
  end

  // incoming write laid over the present word, lane by lane
  always_comb
  begin
    dir_merged  = merge_lanes(dir_word, req.dat, req.sel);
    func_merged = merge_lanes(func_word, req.dat, req.sel);
    dout_merged = merge_lanes(dout_word, req.dat, req.sel);
  end

  // bus state machine: one wait state, ack for exactly one cycle
  always_comb
  begin
    next_bus_state = bus_state;
    unique case (bus_state)
      gp5_pkg::GP5_BUS_IDLE:
      begin
        if (req_valid)
        begin
          next_bus_state = gp5_pkg::GP5_BUS_ACK;
        end
      end
      gp5_pkg::GP5_BUS_ACK:
      begin
        next_bus_state = gp5_pkg::GP5_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state <= gp5_pkg::GP5_BUS_IDLE;
    end
    else
    begin
      bus_state <= next_bus_state;
    end
  end

  // ack follows the state directly, dropped the cycle after it is given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= (bus_state == gp5_pkg::GP5_BUS_IDLE) & req_valid;
    end
  end

  // read mux; unmapped addresses answer with zero rather than hang the bus
  always_comb
  begin
    next_rdata = gp5_pkg::GP5_ZERO;
    if (hit_func)
    begin
      next_rdata = func_word;
    end
    else if (hit_dir)
    begin
      next_rdata = dir_word;
    end
    else if (hit_dout)
    begin
      next_rdata = dout_word;
    end
    else if (hit_din)
    begin
      next_rdata = din_word;
    end
  end

  // read data captured with the request, so it is stable for the whole ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= gp5_pkg::GP5_ZERO;
    end
    else if ((bus_state == gp5_pkg::GP5_BUS_IDLE) & req_valid & ~req.we)
    begin
      wb_dat_o <= next_rdata;
    end
  end

  // direction and pull-up word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pullup_enable_bits <= gp5_pkg::GP5_DIR_RST[gp5_pkg::GP5_PU_LSB +: NPINS];
      output_enable_bits <= gp5_pkg::GP5_DIR_RST[gp5_pkg::GP5_OE_LSB +: NPINS];
    end
    else if (wr_fire & hit_dir)
    begin
      // each bit lands in its own flop, so pins change direction alone
      pullup_enable_bits <= dir_merged[gp5_pkg::GP5_PU_LSB +: NPINS];
      output_enable_bits <= dir_merged[gp5_pkg::GP5_OE_LSB +: NPINS];
    end
  end

  // output value: only the low bits exist, so upper writes vanish
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      output_value_bits <= gp5_pkg::GP5_DOUT_RST[NPINS-1:0];
    end
    else if (wr_fire & hit_dout)
    begin
      output_value_bits <= dout_merged[NPINS-1:0];
    end
    // no clear on mode change, so the value waits until the pin drives
  end

  // function selectors, plain I/O after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_function_selectors <= gp5_pkg::GP5_FUNC_RST[FNW-1:0];
    end
    else if (wr_fire & hit_func)
    begin
      pin_function_selectors <= func_merged[FNW-1:0];
    end
  end

  // pad levels cross in through two flops before anything reads them
  gp5_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pad_in_i),
    .sync_o  (pin_level_bits)
  );

  // pad drivers, selected per pin
  gp5_pin_mux #(
    .NPINS (NPINS)
  ) u_mux (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .fn_sel_i  (pin_function_selectors),
    .io_oe_i   (output_enable_bits),
    .io_out_i  (output_value_bits),
    .alt_pad_i (alt_pad_i),
    .pad_out_o (pad_out_o),
    .pad_oe_o  (pad_oe_o)
  );

  // pull-ups follow the register whatever the pin function
  assign pullup_en_o = pullup_enable_bits;

  // peripherals see the same synchronised levels and the selector state
  assign pin_level_o = pin_level_bits;
  assign fn_sel_o    = pin_function_selectors;

endmodule

// *** logic/gp5_sync.sv ***
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ns
module gp5_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// *** verification/gp5_board.sv ***
// board side of the port 5 pins: pad drive, external drivers, pull-ups
`timescale 1ns/1ns
module gp5_board #(
  parameter int NPINS = 13
) (
  input  wire logic             clk_i,
  input  wire logic [NPINS-1:0] pad_out_i,
  input  wire logic [NPINS-1:0] pad_oe_i,
  input  wire logic [NPINS-1:0] pullup_en_i,
  input  wire logic [NPINS-1:0] ext_en_i,
  input  wire logic [NPINS-1:0] ext_val_i,
  output logic      [NPINS-1:0] level_o
);
  logic [NPINS-1:0] float_pat = '0;
  // floating pins wander so a stale level can never pass
  always_ff @(posedge clk_i)
    float_pat <= ~float_pat;
  // pad driver first, then an external driver, then the pull-up
  always_comb
    level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
      | (~pad_oe_i & ~ext_en_i & (pullup_en_i | float_pat));
endmodule

// *** verification/gp5_port_assertions.sv ***
// concurrent checks on the port 5 pin block ports
`timescale 1ns/1ns
module gp5_port_chk #(
  parameter int NPINS = 13
) (
  input wire logic                                clk_i,
  input wire logic                                rst_i,
  input wire logic                                wb_cyc_i,
  input wire logic                                wb_stb_i,
  input wire logic                                wb_we_i,
  input wire logic [31:0]                         wb_adr_i,
  input wire logic [3:0]                          wb_sel_i,
  input wire logic [31:0]                         wb_dat_i,
  input wire logic [31:0]                         wb_dat_o,
  input wire logic                                wb_ack_o,
  input wire logic [NPINS-1:0]                    pad_in_i,
  input wire logic [NPINS-1:0]                    pad_out_o,
  input wire logic [NPINS-1:0]                    pad_oe_o,
  input wire logic [NPINS-1:0]                    pullup_en_o,
  input wire gp5_pkg::gp5_pad_t [NPINS-1:0]       alt_pad_i,
  input wire logic [NPINS-1:0]                    pin_level_o,
  input wire logic [NPINS*gp5_pkg::GP5_FN_W-1:0]  fn_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // answered bus cycles, write with all lanes or any read
  sequence s_wr(a);
    wb_ack_o && wb_we_i && wb_adr_i == a && wb_sel_i == 4'hF;
  endsequence
  sequence s_rd(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  property p_rst; $fell(rst_i) |-> pullup_en_o == 0 && pad_oe_o == 0 && fn_sel_o == 0; endproperty
  property p_pu; s_wr(gp5_pkg::GP5_ADR_DIR) |=> pullup_en_o == $past(wb_dat_i[28:16]); endproperty
  property p_dout;
    s_wr(gp5_pkg::GP5_ADR_DOUT) ##1 fn_sel_o == 0 |=> pad_out_o == $past(wb_dat_i[12:0], 2);
  endproperty
  property p_alt;
    !$past(rst_i) && $past(fn_sel_o[1:0]) != 0
      |-> pad_oe_o[0] == $past(alt_pad_i[0].oe) && pad_out_o[0] == $past(alt_pad_i[0].drive);
  endproperty
  // two flops of synchronisation, so levels lag the pins by two edges
  property p_sync; !$past(rst_i) && !$past(rst_i, 2) |-> pin_level_o == $past(pad_in_i, 2); endproperty
  property p_din; s_rd(gp5_pkg::GP5_ADR_DIN) |-> wb_dat_o == 32'($past(pin_level_o)); endproperty
  property p_unmap;
    wb_ack_o && !wb_we_i && (wb_adr_i[31:4] != 28'hFFF8305 || wb_adr_i[1:0] != 2'h0)
      |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack one cycle after request");
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  a_pu: assert property (p_pu) else $error("pull-up enables not from write");
  a_dout: assert property (p_dout) else $error("pad value not from write");
  a_alt: assert property (p_alt) else $error("alternate pad control lost");
  a_sync: assert property (p_sync) else $error("pin level lag wrong");
  a_din: assert property (p_din) else $error("pin level read wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind gp5_port gp5_port_chk #(.NPINS(NPINS)) gp5_port_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
  .pullup_en_o(pullup_en_o), .alt_pad_i(alt_pad_i), .pin_level_o(pin_level_o),
  .fn_sel_o(fn_sel_o));

// *** verification/gp5_port_tb.sv ***
// self-checking bench for the port 5 pin block
`timescale 1ns/1ns
module gp5_port_tb;
  localparam int          NP  = gp5_pkg::GP5_NPINS;
  localparam logic [31:0] FNC = gp5_pkg::GP5_ADR_FUNC;
  localparam logic [31:0] DIR = gp5_pkg::GP5_ADR_DIR;
  localparam logic [31:0] DOU = gp5_pkg::GP5_ADR_DOUT;
  localparam logic [31:0] DIN = gp5_pkg::GP5_ADR_DIN;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       cyc = 1'b0;
  logic                       stb = 1'b0;
  logic                       we  = 1'b0;
  logic [31:0]                adr = 32'h0;
  logic [3:0]                 sel = 4'h0;
  logic [31:0]                wdat = 32'h0;
  logic [31:0]                rdat;
  logic                       ack;
  logic [NP-1:0]              pin, pout, oe, pu, lvl;
  logic [NP-1:0]              ext_en = '0;
  logic [NP-1:0]              ext_val = '0;
  gp5_pkg::gp5_pad_t [NP-1:0] alt = '0;
  logic [2*NP-1:0]            fn;
  int                         n_mismatch = 0;
  int                         num_checks = 0;
  // 250 MHz
  always #2 clk = ~clk;
  gp5_port gp5_port_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(oe), .pullup_en_o(pu),
    .alt_pad_i(alt), .pin_level_o(lvl), .fn_sel_o(fn));
  gp5_board gp5_board_i (.clk_i(clk), .pad_out_i(pout), .pad_oe_i(oe), .pullup_en_i(pu),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; held until ack is sampled, only the watchdog ends a hang
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  // test sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(DIR, 32'h0000_0000);
    rdc(FNC, 32'h0000_0000);
    chk(32'(pu), 32'h0000_0000);
    $display("test reset done");
    wr(DIR, 32'hFFFF_FFFF, 4'hF);
    rdc(DIR, 32'h1FFF_1FFF);
    chk(32'(pu), 32'h0000_1FFF);
    wr(DIR, 32'h1FFF_0A55, 4'hF);
    wr(DOU, 32'hFFFF_E5A5, 4'hF);
    rdc(DOU, 32'h0000_05A5);
    settle();
    chk(32'(oe), 32'h0000_0A55);
    chk(32'(pout), 32'h0000_05A5);
    rdc(DIN, 32'h0000_15AF);
    ext_en <= '1;
    ext_val <= 13'h0F0F;
    settle();
    rdc(DIN, 32'h0000_050F);
    chk(32'(lvl), 32'h0000_050F);
    $display("test direction done");
    alt <= {NP{2'b10}};
    wr(FNC, 32'h01E7_9E79, 4'hF);
    wr(DOU, 32'h0000_1FFF, 4'hF);
    settle();
    chk(32'(oe), 32'h0000_0000);
    chk(32'(fn), 32'h01E7_9E79);
    rdc(DIN, 32'h0000_0F0F);
    wr(FNC, 32'h0000_0000, 4'hF);
    settle();
    chk(32'(pout), 32'h0000_1FFF);
    chk(32'(oe), 32'h0000_0A55);
    $display("test function done");
    wr(DIN, 32'h0000_0000, 4'hF);
    rdc(DIN, 32'h0000_0F5F);
    wr(DIR, 32'h0000_00FF, 4'h1);
    rdc(DIR, 32'h1FFF_0AFF);
    rdc(DIN + 32'h4, 32'h0000_0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(DIR, 32'h0000_0000);
    chk(32'(pu), 32'h0000_0000);
    $display("test bus done");
    end_of_test();
  end
endmodule
